/* File: design/dtc_pkg.sv */
// constants for the deserializer timing and datapath configuration bank
package dtc_pkg;
  // register offsets
  localparam logic [7:0] DTC_OFS_ERR_TALLY = 8'h25;
  localparam logic [7:0] DTC_OFS_CLK_HIGH = 8'h26;
  localparam logic [7:0] DTC_OFS_CLK_LOW = 8'h27;
  localparam logic [7:0] DTC_OFS_PATH_SETUP = 8'h28;
  // reset values
  localparam logic [7:0] DTC_RST_ERR_TALLY = 8'h00;
  localparam logic [7:0] DTC_RST_CLK_HIGH = 8'h83;
  localparam logic [7:0] DTC_RST_CLK_LOW = 8'h84;
  localparam logic [7:0] DTC_RST_PATH_SETUP = 8'h00;
  localparam logic [7:0] DTC_ERR_TALLY_MAX = 8'hff;
  // field positions of the path setup register
  localparam int DTC_BIT_KEEP_LOCAL = 7;
  localparam int DTC_BIT_VIDEO_OFF = 5;
  localparam int DTC_BIT_DUAL_LINK = 4;
  localparam int DTC_BIT_ALT_AUDIO = 3;
  localparam int DTC_BIT_AUDIO_OFF = 2;
  localparam int DTC_BIT_SYNC_BITS = 1;
  localparam int DTC_BIT_SURROUND = 0;
  // bits 5..0 are the ones the forward channel loads
  localparam logic [7:0] DTC_FC_LOAD_MASK = 8'h3f;
  // input mode codes of the receive control
  localparam logic [1:0] DTC_MODE_AUTO = 2'h0;
  localparam logic [1:0] DTC_MODE_DUAL = 2'h1;
  // timing: one field unit is 50 ns, clock period 50 ns
  localparam int DTC_UNIT_NS = 50;
  localparam int DTC_CLK_NS = 50;
  localparam int DTC_UNIT_CYC = (DTC_UNIT_NS + DTC_CLK_NS - 1) / DTC_CLK_NS;
  localparam int DTC_CNT_W = 12;
  // clock generator states, gray along idle -> high -> low
  typedef enum logic [1:0] {
    DTC_SCL_IDLE = 2'b00,
    DTC_SCL_HIGH = 2'b01,
    DTC_SCL_LOW = 2'b11
  } dtc_scl_state_t;
endpackage

/* File: design/dtc_scl_timer.sv */
// i2c master clock pulse-width generator and slave sda setup delay
`timescale 1ns/1ps
module dtc_scl_timer
  import dtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [7:0] i_high_units,
  input wire logic [7:0] i_low_units,
  input wire logic i_master_run,
  input wire logic i_setup_start,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_setup_done
);
  // units to cycles; a zero field still gives one unit so the clock never stalls
  function automatic logic [DTC_CNT_W-1:0] dtc_cycles(input logic [7:0] units);
    logic [7:0] u;
    u = (units == 8'h00) ? 8'h01 : units;
    return DTC_CNT_W'({4'h0, u} * DTC_UNIT_CYC);
  endfunction

  dtc_scl_state_t state_reg, state_next;
  logic [DTC_CNT_W-1:0] cnt_reg, cnt_next;
  logic oe_reg, oe_next;
  logic [DTC_CNT_W-1:0] su_cnt_reg, su_cnt_next;
  logic su_busy_reg, su_busy_next;
  logic su_done_reg, su_done_next;

  // master clock: released (high) for the high field, driven low for the low field
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    oe_next = oe_reg;
    case (state_reg)
      DTC_SCL_IDLE: begin
        oe_next = 1'b0;
        if (i_master_run) begin
          state_next = DTC_SCL_HIGH;
          cnt_next = dtc_cycles(i_high_units) - 12'h001;
        end
      end
      DTC_SCL_HIGH: begin
        oe_next = 1'b0;
        if (cnt_reg != 12'h000) begin
          cnt_next = cnt_reg - 12'h001;
        end else if (!i_master_run) begin
          state_next = DTC_SCL_IDLE;
        end else begin
          state_next = DTC_SCL_LOW;
          oe_next = 1'b1;
          cnt_next = dtc_cycles(i_low_units) - 12'h001;
        end
      end
      DTC_SCL_LOW: begin
        oe_next = 1'b1;
        if (cnt_reg != 12'h000) begin
          cnt_next = cnt_reg - 12'h001;
        end else begin
          // always finish a low phase with a release so the bus is never left held
          state_next = DTC_SCL_HIGH;
          oe_next = 1'b0;
          cnt_next = dtc_cycles(i_high_units) - 12'h001;
        end
      end
      default: begin
        state_next = DTC_SCL_IDLE;
        oe_next = 1'b0;
      end
    endcase
  end

  // slave setup delay: data held this long before the stretched clock is let go
  always_comb begin
    su_cnt_next = su_cnt_reg;
    su_busy_next = su_busy_reg;
    su_done_next = 1'b0;
    if (i_setup_start) begin
      su_busy_next = 1'b1;
      su_cnt_next = dtc_cycles(i_low_units) - 12'h001;
    end else if (su_busy_reg) begin
      if (su_cnt_reg == 12'h000) begin
        su_busy_next = 1'b0;
        su_done_next = 1'b1;
      end else begin
        su_cnt_next = su_cnt_reg - 12'h001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= DTC_SCL_IDLE;
      cnt_reg <= 12'h000;
      oe_reg <= 1'b0;
      su_cnt_reg <= 12'h000;
      su_busy_reg <= 1'b0;
      su_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      su_cnt_reg <= su_cnt_next;
      su_busy_reg <= su_busy_next;
      su_done_reg <= su_done_next;
    end
  end

  assign o_scl_o = 1'b0; // open drain: only ever pulls low
  assign o_scl_oe = oe_reg;
  assign o_setup_done = su_done_reg;
endmodule

/* File: design/dtc_config_bank.sv */
// timing and datapath configuration registers of the deserializer
`timescale 1ns/1ps
module dtc_config_bank
  import dtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_fc_load,
  input wire logic [7:0] i_fc_data,
  input wire logic i_selftest_en,
  input wire logic i_selftest_err,
  input wire logic [1:0] i_input_mode,
  input wire logic i_master_run,
  input wire logic i_setup_start,
  input wire logic i_audio_word_clk,
  input wire logic i_audio_data,
  input wire logic i_spare_zero_out,
  input wire logic i_spare_one_out,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_setup_done,
  output logic o_video_disabled,
  output logic o_rx_dual_link,
  output logic o_sync_bits_present,
  output logic o_surround_en,
  output logic o_audio_out_en,
  output logic o_audio_data,
  output logic o_spare_pin_zero,
  output logic o_spare_pin_one
);
  // bank registers and their next values
  logic [7:0] tally_reg, tally_next;
  logic en_d_reg, en_d_next;
  logic [7:0] high_reg, high_next;
  logic [7:0] low_reg, low_next;
  logic [7:0] path_reg, path_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic wr_high, wr_low, wr_path;

  // one decode shared by the three writable offsets
  function automatic logic dtc_hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  // write decode; the read-only tally and unmapped offsets hit nothing
  assign wr_high = dtc_hit(i_reg_wr, i_reg_addr, DTC_OFS_CLK_HIGH);
  assign wr_low = dtc_hit(i_reg_wr, i_reg_addr, DTC_OFS_CLK_LOW);
  assign wr_path = dtc_hit(i_reg_wr, i_reg_addr, DTC_OFS_PATH_SETUP);

  // self-test tally; writes to it are ignored, it is read only
  // a new run restarts from zero even if an error lands in the same cycle
  always_comb begin
    en_d_next = i_selftest_en;
    tally_next = tally_reg;
    if (i_selftest_en && !en_d_reg) begin
      tally_next = DTC_RST_ERR_TALLY;
    end else if (i_selftest_err && (tally_reg != DTC_ERR_TALLY_MAX)) begin
      tally_next = tally_reg + 8'h01;
    end
  end

  // timing fields, plain read/write
  // the timer takes a new value at its next phase boundary, never mid-phase
  always_comb begin
    high_next = wr_high ? i_reg_wdata : high_reg;
    low_next = wr_low ? i_reg_wdata : low_reg;
  end

  // path setup: a local write wins over a forward-channel load in the same cycle,
  // since software expects what it just wrote to stick
  // reset contents stay zero until a local write or the serializer's first load arrives
  always_comb begin
    path_next = path_reg;
    if (wr_path) begin
      path_next = i_reg_wdata;
    end else if (i_fc_load && !path_reg[DTC_BIT_KEEP_LOCAL]) begin
      path_next = (path_reg & ~DTC_FC_LOAD_MASK) | (i_fc_data & DTC_FC_LOAD_MASK);
    end
  end

  // read port: answer one cycle after the strobe, unmapped offsets read zero
  // the answer is registered, so back-to-back reads each land one cycle on
  always_comb begin
    rvalid_next = i_reg_rd;
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      case (i_reg_addr)
        DTC_OFS_ERR_TALLY: rdata_next = tally_reg;
        DTC_OFS_CLK_HIGH: rdata_next = high_reg;
        DTC_OFS_CLK_LOW: rdata_next = low_reg;
        DTC_OFS_PATH_SETUP: rdata_next = path_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // bank registers; reset restores the default field values
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tally_reg <= DTC_RST_ERR_TALLY;
      en_d_reg <= 1'b0;
      high_reg <= DTC_RST_CLK_HIGH;
      low_reg <= DTC_RST_CLK_LOW;
      path_reg <= DTC_RST_PATH_SETUP;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      tally_reg <= tally_next;
      en_d_reg <= en_d_next;
      high_reg <= high_next;
      low_reg <= low_next;
      path_reg <= path_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // datapath steering outputs, registered so the pins never glitch
  logic vid_off_reg, vid_off_next;
  logic dual_reg, dual_next;
  logic sync_reg, sync_next;
  logic surr_reg, surr_next;
  logic aud_en_reg, aud_en_next;
  logic aud_reg, aud_next;
  logic sp0_reg, sp0_next;
  logic sp1_reg, sp1_next;
  logic dual_sel, alt_on, audio_off;

  // auto mode follows the loaded link-mode bit; software forcing goes through input mode
  // codes 2 and 3 pick one input, so the receiver is never dual there
  assign dual_sel = (i_input_mode == DTC_MODE_AUTO) ? path_reg[DTC_BIT_DUAL_LINK] :
    (i_input_mode == DTC_MODE_DUAL);
  assign alt_on = path_reg[DTC_BIT_ALT_AUDIO];
  // audio off gates the serial output; the spare pins keep their own selection
  assign audio_off = path_reg[DTC_BIT_AUDIO_OFF];

  // next values of the steering outputs, one cycle behind the register bits
  always_comb begin
    vid_off_next = path_reg[DTC_BIT_VIDEO_OFF];
    dual_next = dual_sel;
    sync_next = path_reg[DTC_BIT_SYNC_BITS];
    surr_next = path_reg[DTC_BIT_SURROUND];
    aud_en_next = !audio_off;
    aud_next = i_audio_data && !audio_off;
    // alternate audio borrows the spare pins: data on pin zero, word clock on pin one
    sp0_next = alt_on ? i_audio_data : i_spare_zero_out;
    sp1_next = alt_on ? i_audio_word_clk : i_spare_one_out;
  end

  // steering registers; reset clears every pin, which then follows the path bits and inputs from the next cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      vid_off_reg <= 1'b0;
      dual_reg <= 1'b0;
      sync_reg <= 1'b0;
      surr_reg <= 1'b0;
      aud_en_reg <= 1'b0;
      aud_reg <= 1'b0;
      sp0_reg <= 1'b0;
      sp1_reg <= 1'b0;
    end else begin
      vid_off_reg <= vid_off_next;
      dual_reg <= dual_next;
      sync_reg <= sync_next;
      surr_reg <= surr_next;
      aud_en_reg <= aud_en_next;
      aud_reg <= aud_next;
      sp0_reg <= sp0_next;
      sp1_reg <= sp1_next;
    end
  end

  // every port but the tied-low o_scl_o is a flop output, nothing combinational reaches the pins
  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_video_disabled = vid_off_reg;
  assign o_rx_dual_link = dual_reg;
  assign o_sync_bits_present = sync_reg;
  assign o_surround_en = surr_reg;
  assign o_audio_out_en = aud_en_reg;
  assign o_audio_data = aud_reg;
  assign o_spare_pin_zero = sp0_reg;
  assign o_spare_pin_one = sp1_reg;

  // clock timing for the local master and the bridged slave
  // the slave setup delay shares the low field, so one write retunes both
  dtc_scl_timer u_timer (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_high_units(high_reg),
    .i_low_units(low_reg),
    .i_master_run(i_master_run),
    .i_setup_start(i_setup_start),
    .o_scl_o(o_scl_o),
    .o_scl_oe(o_scl_oe),
    .o_setup_done(o_setup_done)
  );
endmodule

/* File: tb/dtc_config_bank_asserts.sv */
// port assertions for the configuration bank
`timescale 1ns/1ps
module dtc_config_bank_asserts
  import dtc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_reg_rd,
  input wire logic o_reg_rvalid,
  input wire logic [1:0] i_input_mode,
  input wire logic i_setup_start,
  input wire logic i_audio_data,
  input wire logic i_spare_zero_out,
  input wire logic o_scl_o,
  input wire logic o_setup_done,
  input wire logic o_rx_dual_link,
  input wire logic o_audio_data,
  input wire logic o_spare_pin_zero
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // register port answers exactly one cycle on
  property p_rd_ans; i_reg_rd |=> o_reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_src; o_reg_rvalid |-> $past(i_reg_rd); endproperty
  a_rd_src: assert property (p_rd_src) else $error("stray read answer");
  // open drain clock never drives high
  property p_scl_o; o_scl_o == 1'b0; endproperty
  a_scl_o: assert property (p_scl_o) else $error("clock driven high");
  // setup delay is never shorter than two cycles, done is a pulse
  property p_setup; i_setup_start |=> !o_setup_done; endproperty
  a_setup: assert property (p_setup) else $error("setup done too early");
  property p_done; o_setup_done |=> !o_setup_done; endproperty
  a_done: assert property (p_done) else $error("setup done not a pulse");
  property p_dual; i_input_mode == DTC_MODE_DUAL |=> o_rx_dual_link; endproperty
  a_dual: assert property (p_dual) else $error("forced dual ignored");
  property p_single; i_input_mode[1] |=> !o_rx_dual_link; endproperty
  a_single: assert property (p_single) else $error("forced single ignored");
  property p_audio; o_audio_data |-> $past(i_audio_data); endproperty
  a_audio: assert property (p_audio) else $error("audio data from nowhere");
  property p_spare; o_spare_pin_zero |-> $past(i_audio_data) || $past(i_spare_zero_out);
  endproperty
  a_spare: assert property (p_spare) else $error("spare pin from nowhere");
  c_done: cover property (o_setup_done);
  c_dual: cover property (o_rx_dual_link);
  c_alt: cover property (o_spare_pin_zero && !i_spare_zero_out);
endmodule

bind dtc_config_bank dtc_config_bank_asserts u_chk (.i_clock(i_clock), .i_srst(i_srst),
  .i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid), .i_input_mode(i_input_mode),
  .i_setup_start(i_setup_start), .i_audio_data(i_audio_data), .o_scl_o(o_scl_o),
  .i_spare_zero_out(i_spare_zero_out), .o_setup_done(o_setup_done),
  .o_rx_dual_link(o_rx_dual_link), .o_audio_data(o_audio_data),
  .o_spare_pin_zero(o_spare_pin_zero));

/* File: tb/dtc_ser_model.sv */
// remote serializer model driving forward channel updates
`timescale 1ns/1ps
module dtc_ser_model (
  input wire logic i_clock,
  input wire logic i_send,
  input wire logic [7:0] i_cfg,
  output logic o_fc_load,
  output logic [7:0] o_fc_data
);
  initial o_fc_load = 1'b0;
  initial o_fc_data = 8'h00;
  // data is only valid with the load pulse, so it toggles between sends
  always @(posedge i_clock) begin
    o_fc_load <= i_send;
    o_fc_data <= i_send ? i_cfg : ~o_fc_data;
  end
endmodule

/* File: tb/dtc_config_bank_tb.sv */
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module dtc_config_bank_tb
  import dtc_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} dtc_row_t;
  logic i_clock, i_srst, i_reg_wr, i_reg_rd, i_selftest_en, i_selftest_err, i_master_run;
  logic i_setup_start, i_audio_word_clk, i_audio_data, i_spare_zero_out, i_spare_one_out;
  logic send, i_fc_load, o_reg_rvalid, o_scl_o, o_scl_oe, o_setup_done, o_video_disabled;
  logic o_rx_dual_link, o_sync_bits_present, o_surround_en, o_audio_out_en, o_audio_data;
  logic o_spare_pin_zero, o_spare_pin_one;
  logic [7:0] i_reg_addr, i_reg_wdata, cfg, o_reg_rdata, i_fc_data, v;
  logic [1:0] i_input_mode;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  // reset values, an unmapped read, a read-only write, then timing fields
  dtc_row_t rows [8] = '{'{1'b0, 8'h25, 8'h00, 8'h00}, '{1'b0, 8'h26, 8'h00, 8'h83},
    '{1'b0, 8'h27, 8'h00, 8'h84}, '{1'b0, 8'h28, 8'h00, 8'h00}, '{1'b0, 8'h30, 8'h00, 8'h00},
    '{1'b1, 8'h25, 8'h55, 8'h00}, '{1'b1, 8'h26, 8'h03, 8'h03}, '{1'b1, 8'h27, 8'h02, 8'h02}};
  dtc_config_bank uut (.i_clock(i_clock), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_fc_load(i_fc_load),
    .i_fc_data(i_fc_data), .i_selftest_en(i_selftest_en), .i_selftest_err(i_selftest_err),
    .i_input_mode(i_input_mode), .i_master_run(i_master_run), .i_setup_start(i_setup_start),
    .i_audio_word_clk(i_audio_word_clk), .i_audio_data(i_audio_data),
    .i_spare_zero_out(i_spare_zero_out), .i_spare_one_out(i_spare_one_out),
    .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .o_setup_done(o_setup_done),
    .o_video_disabled(o_video_disabled), .o_rx_dual_link(o_rx_dual_link),
    .o_sync_bits_present(o_sync_bits_present), .o_surround_en(o_surround_en),
    .o_audio_out_en(o_audio_out_en), .o_audio_data(o_audio_data),
    .o_spare_pin_zero(o_spare_pin_zero), .o_spare_pin_one(o_spare_pin_one));
  dtc_ser_model u_ser (.i_clock(i_clock), .i_send(send), .i_cfg(cfg),
    .o_fc_load(i_fc_load), .o_fc_data(i_fc_data));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // inputs always move 5 ns after the rising edge
  task tick;
    @(posedge i_clock);
    #5;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick;
    i_reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    tick;
    i_reg_rd = 1'b0;
    chk({7'h00, o_reg_rvalid}, 8'h01);
    d = o_reg_rdata;
    tick;
    chk({7'h00, o_reg_rvalid}, 8'h00);
  endtask
  // one update from the serializer, outputs settle three edges later
  task fc(input logic [7:0] d);
    cfg = d;
    send = 1'b1;
    tick;
    send = 1'b0;
    repeat (3) tick;
  endtask
  // counts cycles while the clock enable stays at the given level
  task width(input logic lvl);
    n = 0;
    while (o_scl_oe === lvl && n < 300) begin
      tick;
      n++;
    end
  endtask
  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clock);
    miscompares++;
    print_verdict;
  end
  initial begin
    {i_reg_wr, i_reg_rd, i_selftest_en, i_selftest_err, i_master_run, send} = 6'h00;
    {i_setup_start, i_audio_word_clk, i_audio_data, i_spare_zero_out, i_spare_one_out} = 5'h00;
    {i_reg_addr, i_reg_wdata, cfg} = 24'h000000;
    i_input_mode = DTC_MODE_AUTO;
    i_srst = 1'b1;
    repeat (12) @(posedge i_clock);
    #5;
    i_srst = 1'b0;
    foreach (rows[k]) begin
      if (rows[k].w)
        wr(rows[k].a, rows[k].d);
      rd(rows[k].a, v);
      chk(v, rows[k].e);
    end
    $display("test register table done");
    fc(8'h3f);
    rd(DTC_OFS_PATH_SETUP, v);
    chk(v, 8'h3f);
    chk({3'h0, o_video_disabled, o_rx_dual_link, o_sync_bits_present, o_surround_en,
      o_audio_out_en}, 8'h1e);
    wr(DTC_OFS_PATH_SETUP, 8'h88);
    fc(8'h37);
    rd(DTC_OFS_PATH_SETUP, v);
    chk(v, 8'h88);
    {i_audio_data, i_spare_one_out} = 2'h3;
    repeat (2) tick;
    chk({4'h0, o_spare_pin_zero, o_spare_pin_one, o_audio_data, o_video_disabled}, 8'h0a);
    i_input_mode = DTC_MODE_DUAL;
    repeat (2) tick;
    chk({7'h00, o_rx_dual_link}, 8'h01);
    wr(DTC_OFS_PATH_SETUP, 8'h90);
    {i_audio_data, i_spare_zero_out} = 2'h1;
    i_input_mode = 2'h2;
    repeat (2) tick;
    chk({5'h00, o_spare_pin_zero, o_spare_pin_one, o_rx_dual_link}, 8'h06);
    i_input_mode = DTC_MODE_AUTO;
    repeat (2) tick;
    chk({7'h00, o_rx_dual_link}, 8'h01);
    $display("test path setup done");
    i_master_run = 1'b1;
    width(1'b0);
    width(1'b1);
    chk(n[7:0], 8'h02);
    width(1'b0);
    chk(n[7:0], 8'h03);
    i_master_run = 1'b0;
    repeat (10) tick;
    i_setup_start = 1'b1;
    tick;
    i_setup_start = 1'b0;
    n = 0;
    while (!o_setup_done && n < 300) begin
      tick;
      n++;
    end
    chk(n[7:0], 8'h02);
    $display("test timing done");
    i_selftest_en = 1'b1;
    tick;
    i_selftest_err = 1'b1;
    repeat (3) tick;
    i_selftest_err = 1'b0;
    rd(DTC_OFS_ERR_TALLY, v);
    chk(v, 8'h03);
    i_selftest_err = 1'b1;
    repeat (300) tick;
    i_selftest_err = 1'b0;
    rd(DTC_OFS_ERR_TALLY, v);
    chk(v, 8'hff);
    i_selftest_en = 1'b0;
    tick;
    i_selftest_en = 1'b1;
    repeat (2) tick;
    rd(DTC_OFS_ERR_TALLY, v);
    chk(v, 8'h00);
    i_srst = 1'b1;
    tick;
    i_srst = 1'b0;
    rd(DTC_OFS_CLK_HIGH, v);
    chk(v, 8'h83);
    $display("test self-test and reset done");
    print_verdict;
  end
endmodule
